/* rtl/cfgee_regs.vh */
`ifndef CFGEE_REGS_VH
`define CFGEE_REGS_VH

// Clock period of the system clock.
`define CFGEE_CLK_NS          8'd10

// Register offsets (byte addresses of the serial register space).
`define CFGEE_OFS_SLV         6'h01
`define CFGEE_OFS_CAP         6'h05
`define CFGEE_OFS_SAVE        6'h06
`define CFGEE_OFS_BCNT        6'h0c
`define CFGEE_OFS_CTAB        6'h18
`define CFGEE_REG_TOP         7'h40
`define CFGEE_REG_LAST        6'h3f

// Field positions.
`define CFGEE_CAP_MSB         7
`define CFGEE_CAP_LSB         3
`define CFGEE_CAP_RSV         3'h0
`define CFGEE_BCNT_MSB        7
`define CFGEE_BCNT_LSB        1
`define CFGEE_SAVE_BIT        0
`define CFGEE_LOCK_BIT        1
`define CFGEE_PINS_BIT        2
`define CFGEE_BUSY_BIT        6

// Reset values and the load capacitance limit.
`define CFGEE_CAP_RST         5'h0a
`define CFGEE_BCNT_RST        7'h40
`define CFGEE_BYTE_RST        8'h00
`define CFGEE_CAP_MAX         5'h14

// Command byte: bit 7 high selects a single byte access, low a block access.
`define CFGEE_CMD_BYTE_BIT    7

// Time to program one nonvolatile byte.
`define CFGEE_EE_BYTE_NS      8'd100
`define CFGEE_EE_BYTE_CYC     (`CFGEE_EE_BYTE_NS / `CFGEE_CLK_NS)

`endif

/* rtl/cfgee_serial_slave.v */
`timescale 1ns/1ns
`include "cfgee_regs.vh"

module cfgee_serial_slave (
   // Clock and reset
   input  wire       clk_i,
   input  wire       rst_n_i,
   // Synchronised bus lines
   input  wire       scl_i,
   input  wire       sda_i,
   input  wire [6:0] dev_addr_i,
   // Register access
   input  wire [7:0] rd_data_i,
   input  wire [6:0] byte_count_i,
   output wire [6:0] rd_addr_o,
   output reg        wr_o,
   output reg  [6:0] wr_addr_o,
   output reg  [7:0] wr_data_o,
   // Data line drive
   output reg        sda_oe_o
);

   localparam ST_IDLE = 3'd0;
   localparam ST_RX   = 3'd1;
   localparam ST_RACK = 3'd2;
   localparam ST_TX   = 3'd3;
   localparam ST_TACK = 3'd4;

   reg  [2:0] st_q;
   reg        scl_q;
   reg        sda_q;
   reg  [7:0] sh_q;
   reg  [3:0] cnt_q;
   reg  [1:0] idx_q;
   reg        rw_q;
   reg        blk_q;
   reg        cnt_sent_q;
   reg        nack_q;
   reg  [6:0] ofs_q;
   wire       rise  = scl_i & ~scl_q;
   wire       fall  = ~scl_i & scl_q;
   wire       start = scl_i & scl_q & sda_q & ~sda_i;
   wire       stop  = scl_i & scl_q & ~sda_q & sda_i;
   // Block reads announce the byte count before the first register byte.
   wire       cnt_next = blk_q & ~cnt_sent_q;
   wire [7:0] tx_byte  = cnt_next ? {1'b0, byte_count_i} : rd_data_i;

   assign rd_addr_o = ofs_q;

   always @(posedge clk_i) begin
      wr_o <= 1'b0;
      if (!rst_n_i) begin
         st_q       <= ST_IDLE;
         scl_q      <= 1'b1;
         sda_q      <= 1'b1;
         sh_q       <= 8'h00;
         cnt_q      <= 4'h0;
         idx_q      <= 2'd0;
         rw_q       <= 1'b0;
         blk_q      <= 1'b0;
         cnt_sent_q <= 1'b0;
         nack_q     <= 1'b0;
         ofs_q      <= 7'h00;
         wr_addr_o  <= 7'h00;
         wr_data_o  <= 8'h00;
         sda_oe_o   <= 1'b0;
      end else begin
         scl_q <= scl_i;
         sda_q <= sda_i;
         if (start) begin
            st_q       <= ST_RX;
            cnt_q      <= 4'h0;
            idx_q      <= 2'd0;
            cnt_sent_q <= 1'b0;
            sda_oe_o   <= 1'b0;
         end else if (stop) begin
            st_q     <= ST_IDLE;
            sda_oe_o <= 1'b0;
         end else begin
            case (st_q)
               ST_RX: begin
                  if (rise) begin
                     sh_q  <= {sh_q[6:0], sda_i};
                     cnt_q <= cnt_q + 4'h1;
                  end else if (fall && cnt_q == 4'h8) begin
                     cnt_q <= 4'h0;
                     if (idx_q == 2'd0) begin
                        if (sh_q[7:1] == dev_addr_i) begin
                           rw_q     <= sh_q[0];
                           st_q     <= ST_RACK;
                           sda_oe_o <= 1'b1;
                           idx_q    <= 2'd1;
                        end else begin
                           st_q <= ST_IDLE;
                        end
                     end else if (idx_q == 2'd1) begin
                        ofs_q    <= sh_q[6:0];
                        blk_q    <= ~sh_q[`CFGEE_CMD_BYTE_BIT];
                        idx_q    <= 2'd2;
                        st_q     <= ST_RACK;
                        sda_oe_o <= 1'b1;
                     end else begin
                        wr_o      <= 1'b1;
                        wr_addr_o <= ofs_q;
                        wr_data_o <= sh_q;
                        ofs_q     <= ofs_q + 7'h01;
                        st_q      <= ST_RACK;
                        sda_oe_o  <= 1'b1;
                     end
                  end
               end
               ST_RACK: begin
                  if (fall) begin
                     if (rw_q) begin
                        st_q     <= ST_TX;
                        sh_q     <= tx_byte;
                        sda_oe_o <= ~tx_byte[7];
                        if (cnt_next) begin
                           cnt_sent_q <= 1'b1;
                        end else begin
                           ofs_q <= ofs_q + 7'h01;
                        end
                     end else begin
                        st_q     <= ST_RX;
                        sda_oe_o <= 1'b0;
                     end
                  end
               end
               ST_TX: begin
                  if (fall) begin
                     if (cnt_q == 4'h7) begin
                        cnt_q    <= 4'h0;
                        st_q     <= ST_TACK;
                        sda_oe_o <= 1'b0;
                     end else begin
                        cnt_q    <= cnt_q + 4'h1;
                        sh_q     <= {sh_q[6:0], 1'b0};
                        sda_oe_o <= ~sh_q[6];
                     end
                  end
               end
               ST_TACK: begin
                  if (rise) begin
                     nack_q <= sda_i;
                  end else if (fall) begin
                     if (nack_q) begin
                        st_q <= ST_IDLE;
                     end else begin
                        st_q     <= ST_TX;
                        sh_q     <= tx_byte;
                        sda_oe_o <= ~tx_byte[7];
                        if (cnt_next) begin
                           cnt_sent_q <= 1'b1;
                        end else begin
                           ofs_q <= ofs_q + 7'h01;
                        end
                     end
                  end
               end
               default: begin
                  sda_oe_o <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule

/* rtl/cfgee_store_ctrl.v */
// Function
// - Load capacitance code, 1 pF steps, max 20
// - Seven-bit block read byte count, reset 64
// - Save bit copies configuration into nonvolatile
// - Save starts only on rising edge
// - Reads still answered during save
// - Readable save-in-progress status bit
// - Stored lock refuses further saves
// - Volatile writes still work while locked
// - Lock effective only once stored
// - Stored pin mode disables serial pins
// - Grounded output supply restores serial, address
// - Eight control settings chosen by pins
// - Serial bytes travel MSB first
`timescale 1ns/1ns
`include "cfgee_regs.vh"

module cfgee_store_ctrl #(
   parameter [4:0] SLAVE_ADDR_BASE = 5'h19
) (
   // Clock and reset
   input  wire       SYS_CLK_I,
   input  wire       RST_N_I,
   // Shared pins
   input  wire       CTRL_PIN_0_I,
   input  wire       CTRL_PIN_1_SDA_I,
   input  wire       CTRL_PIN_2_SCL_I,
   input  wire       VDDOUT_GROUNDED_I,
   output wire       SDA_O,
   output wire       SDA_OE_O,
   // Device controls
   output reg  [4:0] LOAD_CAP_PF_O,
   output reg  [7:0] CTRL_SETTING_O,
   output reg  [1:0] SLAVE_ADDR_O,
   output reg        SAVE_IN_PROGRESS_O,
   output reg        NONVOLATILE_LOCK_O,
   output reg        SERIAL_EN_O
);

   localparam SV_IDLE = 1'b0;
   localparam SV_COPY = 1'b1;
   localparam [7:0] BYTE_CYC = `CFGEE_EE_BYTE_CYC;

   reg  [7:0] cfg_q [0:63];
   reg  [7:0] nv_q  [0:63];
   reg  [3:0] pin_m_q;
   reg  [3:0] pin_s_q;
   reg        sv_st_q;
   reg        trig_prev_q;
   reg  [5:0] sv_idx_q;
   reg  [7:0] sv_tmr_q;
   reg        nv_lock_q;
   reg        nv_pins_q;
   integer    i;

   wire       ctrl0_s  = pin_s_q[0];
   wire       sda_s    = pin_s_q[1];
   wire       scl_s    = pin_s_q[2];
   wire       vdd_gnd  = pin_s_q[3];
   wire       ser_en   = ~nv_pins_q | vdd_gnd;
   wire [1:0] slv_bits = vdd_gnd ? 2'b00 : cfg_q[`CFGEE_OFS_SLV][1:0];
   wire       busy     = (sv_st_q == SV_COPY);
   wire       trig     = cfg_q[`CFGEE_OFS_SAVE][`CFGEE_SAVE_BIT];
   wire [6:0] block_read_byte_count   = cfg_q[`CFGEE_OFS_BCNT][`CFGEE_BCNT_MSB:`CFGEE_BCNT_LSB];
   wire [6:0] rd_addr;
   wire       wr;
   wire [6:0] wr_addr;
   wire [7:0] wr_data;
   wire       slv_oe;
   wire [2:0] sel;

   // pins pick setting
   // While the shared pins carry the bus they cannot also select a setting.
   assign sel = ser_en ? {2'b00, ctrl0_s} : {scl_s, sda_s, ctrl0_s};

   // The data line is open drain: only ever pulled low.
   assign SDA_O    = 1'b0;
   assign SDA_OE_O = slv_oe & ser_en;

   function in_range;
      input [6:0] a;
      begin
         in_range = ({1'b0, a} < {1'b0, `CFGEE_REG_TOP});
      end
   endfunction

   function [7:0] rd_value;
      input [6:0] a;
      begin
         if (!in_range(a)) begin
            rd_value = 8'h00;
         end else if (a[5:0] == `CFGEE_OFS_SAVE) begin
            rd_value = cfg_q[a[5:0]];
            rd_value[`CFGEE_BUSY_BIT] = busy;
         end else begin
            rd_value = cfg_q[a[5:0]];
         end
      end
   endfunction

   // Two flip-flops on every pin before any use.
   always @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         // The supply flag resets to its idle low level, so reset shows no false grounded supply.
         pin_m_q <= 4'h7;
         pin_s_q <= 4'h7;
      end else begin
         pin_m_q <= {VDDOUT_GROUNDED_I, CTRL_PIN_2_SCL_I, CTRL_PIN_1_SDA_I, CTRL_PIN_0_I};
         pin_s_q <= pin_m_q;
      end
   end

   cfgee_serial_slave u_slave (
      .clk_i        (SYS_CLK_I),
      .rst_n_i      (RST_N_I),
      .scl_i        (ser_en ? scl_s : 1'b1),
      .sda_i        (ser_en ? sda_s : 1'b1),
      .dev_addr_i   ({SLAVE_ADDR_BASE, slv_bits}),
      .rd_data_i    (rd_value(rd_addr)),
      .byte_count_i (block_read_byte_count),
      .rd_addr_o    (rd_addr),
      .wr_o         (wr),
      .wr_addr_o    (wr_addr),
      .wr_data_o    (wr_data),
      .sda_oe_o     (slv_oe)
   );

   // Volatile configuration space.
   always @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         for (i = 0; i < `CFGEE_REG_TOP; i = i + 1) begin
            cfg_q[i] <= `CFGEE_BYTE_RST;
         end
         cfg_q[`CFGEE_OFS_CAP]  <= {`CFGEE_CAP_RST, `CFGEE_CAP_RSV};
         cfg_q[`CFGEE_OFS_BCNT] <= {`CFGEE_BCNT_RST, 1'b0};
      end else if (wr && in_range(wr_addr) && !busy) begin
         // writes apply live
         // Writes during a save are dropped so the copy stays coherent.
         if (wr_addr[5:0] == `CFGEE_OFS_CAP) begin
            cfg_q[wr_addr[5:0]] <= {wr_data[`CFGEE_CAP_MSB:`CFGEE_CAP_LSB], `CFGEE_CAP_RSV};
         end else if (wr_addr[5:0] == `CFGEE_OFS_SAVE) begin
            cfg_q[wr_addr[5:0]] <= wr_data & ~(8'h01 << `CFGEE_BUSY_BIT);
         end else begin
            cfg_q[wr_addr[5:0]] <= wr_data;
         end
      end
   end

   // Nonvolatile save sequencer.
   always @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         sv_st_q     <= SV_IDLE;
         trig_prev_q <= 1'b0;
         sv_idx_q    <= 6'h00;
         sv_tmr_q    <= 8'h00;
         nv_lock_q   <= 1'b0;
         nv_pins_q   <= 1'b0;
      end else begin
         trig_prev_q <= trig;
         case (sv_st_q)
            SV_IDLE: begin
               if (trig && !trig_prev_q && !nv_lock_q) begin
                  sv_st_q  <= SV_COPY;
                  sv_idx_q <= 6'h00;
                  sv_tmr_q <= BYTE_CYC;
               end
            end
            SV_COPY: begin
               if (sv_tmr_q > 8'h01) begin
                  sv_tmr_q <= sv_tmr_q - 8'h01;
               end else begin
                  sv_tmr_q <= BYTE_CYC;
                  sv_idx_q <= sv_idx_q + 6'h01;
                  if (sv_idx_q == `CFGEE_REG_LAST) begin
                     sv_st_q   <= SV_IDLE;
                     // lock from stored copy
                     // Taken from the stored cells, so only a saved lock or pin mode counts.
                     nv_lock_q <= nv_q[`CFGEE_OFS_SAVE][`CFGEE_LOCK_BIT];
                     nv_pins_q <= nv_q[`CFGEE_OFS_SAVE][`CFGEE_PINS_BIT];
                  end
               end
            end
            default: begin
               sv_st_q <= SV_IDLE;
            end
         endcase
      end
   end

   // The array has no reset: it stands for the nonvolatile cells.
   always @(posedge SYS_CLK_I) begin
      if (busy && sv_tmr_q == 8'h01) begin
         nv_q[sv_idx_q] <= cfg_q[sv_idx_q];
      end
   end

   // Registered control outputs.
   always @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         LOAD_CAP_PF_O      <= `CFGEE_CAP_RST;
         CTRL_SETTING_O     <= 8'h00;
         SLAVE_ADDR_O       <= 2'b00;
         SAVE_IN_PROGRESS_O <= 1'b0;
         NONVOLATILE_LOCK_O <= 1'b0;
         SERIAL_EN_O        <= 1'b1;
      end else begin
         if (cfg_q[`CFGEE_OFS_CAP][`CFGEE_CAP_MSB:`CFGEE_CAP_LSB] > `CFGEE_CAP_MAX) begin
            LOAD_CAP_PF_O <= `CFGEE_CAP_MAX;
         end else begin
            LOAD_CAP_PF_O <= cfg_q[`CFGEE_OFS_CAP][`CFGEE_CAP_MSB:`CFGEE_CAP_LSB];
         end
         CTRL_SETTING_O     <= cfg_q[`CFGEE_OFS_CTAB + {3'b000, sel}];
         SLAVE_ADDR_O       <= slv_bits;
         SAVE_IN_PROGRESS_O <= busy;
         NONVOLATILE_LOCK_O <= nv_lock_q;
         SERIAL_EN_O        <= ser_en;
      end
   end

endmodule

/* bench/cfgee_store_monitor.sv */
`timescale 1ns/1ns
module cfgee_store_monitor (
   // Clock and reset
   input wire       SYS_CLK_I,
   input wire       RST_N_I,
   // Pins
   input wire       VDDOUT_GROUNDED_I,
   input wire       SDA_O,
   input wire       SDA_OE_O,
   // Device controls
   input wire [4:0] LOAD_CAP_PF_O,
   input wire [1:0] SLAVE_ADDR_O,
   input wire       SAVE_IN_PROGRESS_O,
   input wire       NONVOLATILE_LOCK_O,
   input wire       SERIAL_EN_O
);
   reg [9:0] busy_len_q;
   // A counter measures the save, since a long repetition would stall the tools.
   always @(posedge SYS_CLK_I) begin
      if (!RST_N_I || !SAVE_IN_PROGRESS_O) begin
         busy_len_q <= 10'h000;
      end else if (busy_len_q != 10'h3ff) begin
         busy_len_q <= busy_len_q + 10'h001;
      end
   end
   default clocking mon_cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (!RST_N_I);
   sequence s_save_hold;
      SAVE_IN_PROGRESS_O [*8];
   endsequence
   sequence s_idle_hold;
      !SAVE_IN_PROGRESS_O [*8];
   endsequence
   a_cap_clamp: assert property (LOAD_CAP_PF_O <= 5'h14)
      else $error("load cap above maximum");
   a_save_holds: assert property ($rose(SAVE_IN_PROGRESS_O) |-> s_save_hold)
      else $error("save status dropped early");
   a_save_ends: assert property ($rose(SAVE_IN_PROGRESS_O) |-> ##[1:1000] !SAVE_IN_PROGRESS_O)
      else $error("save never completed");
   a_save_length: assert property ($fell(SAVE_IN_PROGRESS_O) |-> busy_len_q == 10'h280)
      else $error("save too short");
   a_no_retrigger: assert property ($fell(SAVE_IN_PROGRESS_O) |-> s_idle_hold)
      else $error("save relaunched without edge");
   a_lock_refuses: assert property (NONVOLATILE_LOCK_O && $past(NONVOLATILE_LOCK_O) |->
      !$rose(SAVE_IN_PROGRESS_O))
      else $error("save started while locked");
   a_lock_stored: assert property ($rose(NONVOLATILE_LOCK_O) |->
      $past(SAVE_IN_PROGRESS_O, 1) || $past(SAVE_IN_PROGRESS_O, 2))
      else $error("lock set without a save");
   a_serial_quiet: assert property (!SERIAL_EN_O |-> !SDA_OE_O)
      else $error("data driven with serial off");
   a_sda_low: assert property (SDA_O == 1'b0)
      else $error("data line driven high");
   a_ground_serial: assert property (VDDOUT_GROUNDED_I [*7] |-> SERIAL_EN_O && SLAVE_ADDR_O == 2'h0)
      else $error("grounded supply did not restore serial");
endmodule

bind cfgee_store_ctrl cfgee_store_monitor mon (
   .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .VDDOUT_GROUNDED_I(VDDOUT_GROUNDED_I), .SDA_O(SDA_O),
   .SDA_OE_O(SDA_OE_O), .LOAD_CAP_PF_O(LOAD_CAP_PF_O), .SLAVE_ADDR_O(SLAVE_ADDR_O),
   .SAVE_IN_PROGRESS_O(SAVE_IN_PROGRESS_O), .NONVOLATILE_LOCK_O(NONVOLATILE_LOCK_O),
   .SERIAL_EN_O(SERIAL_EN_O));

/* bench/cfgee_host_model.sv */
`timescale 1ns/1ns
module cfgee_host_model #(
   parameter [6:0] DEV_ADDR = 7'h64,
   parameter       HALF     = 8
) (
   input  wire SYS_CLK_I,
   input  wire sda_oe_i,
   output wire scl_o,
   output wire sda_o
);
   reg       scl_q = 1'b1;
   reg       low_q = 1'b0;
   reg [6:0] addr  = DEV_ADDR;
   reg [7:0] rx [0:7];
   integer   nacks = 0;
   // The data line has a pull-up, so a released line reads high, never a stale bit.
   assign sda_o = !(low_q || sda_oe_i);
   assign scl_o = scl_q;
   task half;
      repeat (HALF) @(posedge SYS_CLK_I);
   endtask
   // Data moves one cycle after the clock falls, so it never races that edge.
   task bit_io(input b, output r);
      begin
         @(posedge SYS_CLK_I);
         low_q <= !b;
         half;
         scl_q <= 1'b1;
         half;
         r = sda_o;
         scl_q <= 1'b0;
      end
   endtask
   task start;
      begin
         @(posedge SYS_CLK_I);
         low_q <= 1'b0;
         half;
         scl_q <= 1'b1;
         half;
         low_q <= 1'b1;
         half;
         scl_q <= 1'b0;
      end
   endtask
   task stop;
      begin
         @(posedge SYS_CLK_I);
         low_q <= 1'b1;
         half;
         scl_q <= 1'b1;
         half;
         low_q <= 1'b0;
         half;
      end
   endtask
   task put_byte(input [7:0] d);
      reg     r;
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1) bit_io(d[i], r);
         bit_io(1'b1, r);
         if (r !== 1'b0) nacks = nacks + 1;
      end
   endtask
   task xfer(input [7:0] cmd, input [7:0] d, input integer n);
      reg     r;
      integer i;
      integer k;
      begin
         start;
         put_byte({addr, 1'b0});
         put_byte(cmd);
         if (n == 0) begin
            put_byte(d);
         end else begin
            start;
            put_byte({addr, 1'b1});
            for (k = 0; k < n; k = k + 1) begin
               for (i = 7; i >= 0; i = i - 1) bit_io(1'b1, rx[k][i]);
               bit_io(k == n - 1, r);
            end
         end
         stop;
      end
   endtask
endmodule

/* bench/testbench.sv */
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
   $display("unexpected %s exp %h got %h", n, e, g); error_cnt++; end end
module testbench;
   reg        clk     = 1'b0;
   reg        rst_n   = 1'b0;
   reg        pin_0   = 1'b0;
   reg        vdd_gnd = 1'b0;
   wire       scl;
   wire       sda;
   wire       sda_oe;
   wire [4:0] cap;
   wire [7:0] setting;
   wire [1:0] saddr;
   wire       busy;
   wire       lock;
   wire       ser_en;
   integer    error_cnt   = 0;
   integer    checks_done = 0;
   cfgee_store_ctrl dut (
      .SYS_CLK_I(clk), .RST_N_I(rst_n), .CTRL_PIN_0_I(pin_0), .CTRL_PIN_1_SDA_I(sda),
      .CTRL_PIN_2_SCL_I(scl), .VDDOUT_GROUNDED_I(vdd_gnd), .SDA_O(), .SDA_OE_O(sda_oe),
      .LOAD_CAP_PF_O(cap), .CTRL_SETTING_O(setting), .SLAVE_ADDR_O(saddr),
      .SAVE_IN_PROGRESS_O(busy), .NONVOLATILE_LOCK_O(lock), .SERIAL_EN_O(ser_en));
   cfgee_host_model host (.SYS_CLK_I(clk), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
   initial begin
      forever #5 clk = ~clk;
   end
   task wr(input [7:0] off, input [7:0] d);
      host.xfer(8'h80 | off, d, 0);
   endtask
   task rd(input [7:0] off, input [7:0] e, input string nm);
      begin
         host.xfer(8'h80 | off, 8'h00, 1);
         `CHK(nm, e, host.rx[0])
      end
   endtask
   task wait_idle;
      integer n;
      begin
         for (n = 0; n < 1000 && busy !== 1'b0; n++) @(posedge clk);
         `CHK("busy", 1'b0, busy)
      end
   endtask
   task t_reset;
      begin
         `CHK("cap", 5'h0a, cap)
         rd(8'h05, 8'h50, "cap reg");
         rd(8'h0c, 8'h80, "count reg");
         rd(8'h41, 8'h00, "beyond top");
      end
   endtask
   task t_cap;
      reg [7:0] w [0:3];
      integer   i;
      begin
         w = '{8'ha0, 8'hf8, 8'h98, 8'h00};
         for (i = 0; i < 4; i++) begin
            wr(8'h05, w[i]);
            `CHK("cap", (w[i][7:3] > 5'h14) ? 5'h14 : w[i][7:3], cap)
            rd(8'h05, {w[i][7:3], 3'h0}, "cap reg");
         end
      end
   endtask
   task t_count;
      begin
         wr(8'h0c, 8'h08);
         host.xfer(8'h0c, 8'h00, 5);
         `CHK("block count", 8'h04, host.rx[0])
         `CHK("block data", 8'h08, host.rx[1])
      end
   endtask
   task t_save;
      begin
         wr(8'h01, 8'h03);
         host.addr = 7'h67;
         `CHK("slave addr", 2'h3, saddr)
         wr(8'h05, 8'h50);
         wr(8'h06, 8'h01);
         `CHK("busy", 1'b1, busy)
         rd(8'h06, 8'h41, "status");
         wait_idle;
         wr(8'h06, 8'h03);
         `CHK("busy", 1'b0, busy)
         `CHK("lock", 1'b0, lock)
         wr(8'h06, 8'h06);
         wr(8'h06, 8'h07);
         `CHK("busy", 1'b1, busy)
         wait_idle;
         `CHK("lock", 1'b1, lock)
         `CHK("serial", 1'b0, ser_en)
      end
   endtask
   task t_locked;
      integer i;
      begin
         @(posedge clk);
         vdd_gnd <= 1'b1;
         host.addr = 7'h64;
         repeat (8) @(posedge clk);
         `CHK("serial", 1'b1, ser_en)
         `CHK("slave addr", 2'h0, saddr)
         wr(8'h06, 8'h06);
         wr(8'h06, 8'h07);
         `CHK("busy", 1'b0, busy)
         for (i = 0; i < 8; i++) wr(8'h18 + i[7:0], 8'h81 + 8'h11 * i[7:0]);
         `CHK("setting", 8'h81, setting)
         vdd_gnd <= 1'b0;
         repeat (8) @(posedge clk);
         `CHK("serial", 1'b0, ser_en)
         for (i = 0; i < 8; i++) begin
            pin_0 <= i[0];
            host.low_q <= !i[1];
            host.scl_q <= i[2];
            repeat (8) @(posedge clk);
            `CHK("setting", 8'h81 + 8'h11 * i[7:0], setting)
         end
      end
   endtask
   task conclude;
      begin
         if (error_cnt == 0 && checks_done > 0) begin
            $display("verification passed");
         end else begin
            $display("verification failed");
         end
         $finish;
      end
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_reset;
      t_cap;
      t_count;
      t_save;
      t_locked;
      `CHK("missed acks", 0, host.nacks)
      conclude;
   end
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      conclude;
   end
endmodule
